//--- hw/bcrb_top.sv
/*
 board controller register bank: axi4-lite slave with led, volume,
 eeprom byte window and the reset-class logic of the controller.
 assumes one clock mclk, synchronous active-high reset, async pins.
*/
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module bcrb_top
    import bcrb_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // board pins
    input wire logic hard_reset_input,
    input wire logic switch_reset_input,
    output logic [7:0] led_on_bit,
    output logic eeprom_enable,
    output logic [7:0] right_volume_level,
    output logic [7:0] left_volume_level,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    if (ADDR_W < IDX_W + 2 || TICK_COUNT < 2) begin
        $error("bcrb_top: unsupported parameter values");
    end

    typedef struct packed {
        logic [1:0] hard_sync;
        logic [1:0] sw_sync;
        logic sw_prev;
        logic pwr_prev;
        logic [31:0] tick_cnt;
        logic [7:0] led;
        logic [7:0] eep_ctrl;
        logic [7:0] vol_r;
        logic [7:0] vol_l;
        logic [7:0] rst_ctrl;
        logic [7:0] pwr_ctrl;
        logic [7:0] clk_ctrl;
        logic [7:0] clk_stat;
        logic [7:0] irq_stat;
        logic [CAL_REGS-1:0][7:0] cal;
        logic [ALM_REGS-1:0][7:0] alm;
        logic [EEP_BYTES-1:0][7:0] eep;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic [IDX_W-1:0] widx;
        logic [7:0] wbyte;
        logic wlane;
    } bcrb_state_type;

    // window test, used by decode, read and write
    function automatic logic in_window(input logic [IDX_W-1:0] idx);
        in_window = idx >= IDX_EEP_FIRST && idx <= IDX_EEP_LAST;
    endfunction

    function automatic logic reg_hit(input logic [IDX_W-1:0] idx);
        reg_hit = in_window(idx) || idx == IDX_LED
            || idx == IDX_EEP_CTRL || idx == IDX_VOL_R
            || idx == IDX_VOL_L || idx == IDX_CLK_CTRL
            || idx == IDX_CLK_STAT || idx == IDX_IRQ_STAT
            || idx == IDX_RST_CTRL || idx == IDX_PWR_CTRL
            || (idx >= IDX_CAL_FIRST
                && idx < IDX_CAL_FIRST + 10'(CAL_REGS))
            || (idx >= IDX_ALM_FIRST
                && idx < IDX_ALM_FIRST + 10'(ALM_REGS));
    endfunction

    // reinitialise registers; full selects the hard class
    function automatic bcrb_state_type reinit(input bcrb_state_type st,
                                              input logic full);
        bcrb_state_type r;
        r = st;
        r.led = LED_RST;
        r.eep_ctrl = EEP_CTRL_RST;
        r.vol_r = VOL_RST;
        r.vol_l = VOL_RST;
        r.rst_ctrl = RST_CTRL_RST;
        r.pwr_ctrl = PWR_RST;
        r.pwr_prev = PWR_RST[PWR_BIT];
        r.clk_ctrl = CLK_CTRL_RST;
        r.irq_stat = IRQ_RST;
        if (full) begin
            r.clk_stat = CLK_STAT_RST;
            r.alm = {ALM_REGS{ALM_RST}};
            r.cal = {CAL_REGS{CAL_RST}};
            r.tick_cnt = '0;
        end
        reinit = r;
    endfunction

    function automatic bcrb_state_type boot_state();
        bcrb_state_type r;
        r = '0;
        r = reinit(r, 1'b1);
        r.awready = 1'b1;
        r.wready = 1'b1;
        r.arready = 1'b1;
        boot_state = r;
    endfunction

    localparam bcrb_state_type RST_STATE = boot_state();

    function automatic logic [7:0] read_byte(input bcrb_state_type st,
                                             input logic [IDX_W-1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (in_window(idx)) begin
            if (st.eep_ctrl[EEP_EN_BIT]) begin
                v = st.eep[idx[EEP_AW-1:0]];
            end
        end else if (idx >= IDX_CAL_FIRST
                     && idx < IDX_CAL_FIRST + 10'(CAL_REGS)) begin
            v = st.cal[3'(idx - IDX_CAL_FIRST)];
        end else if (idx >= IDX_ALM_FIRST
                     && idx < IDX_ALM_FIRST + 10'(ALM_REGS)) begin
            v = st.alm[3'(idx - IDX_ALM_FIRST)];
        end else begin
            case (idx)
                IDX_LED: v = st.led;
                IDX_EEP_CTRL: v = st.eep_ctrl & EEP_CTRL_MASK;
                IDX_VOL_R: v = st.vol_r;
                IDX_VOL_L: v = st.vol_l;
                IDX_CLK_CTRL: v = st.clk_ctrl;
                IDX_CLK_STAT: v = st.clk_stat;
                IDX_IRQ_STAT: v = st.irq_stat;
                IDX_RST_CTRL: v = st.rst_ctrl;
                IDX_PWR_CTRL: v = st.pwr_ctrl;
                default: v = 8'h00;
            endcase
        end
        read_byte = v;
    endfunction

    bcrb_state_type s;
    bcrb_state_type next_s;
    logic press;
    logic class_a;
    logic class_b;
    logic class_c;
    logic class_d;
    logic wr_fire;
    logic tick;

    always_comb begin
        next_s = s;
        // pin synchronisers and switch press
        next_s.hard_sync = {s.hard_sync[0], hard_reset_input};
        next_s.sw_sync = {s.sw_sync[0], switch_reset_input};
        next_s.sw_prev = s.sw_sync[1];
        press = s.sw_sync[1] & ~s.sw_prev;
        class_a = s.hard_sync[1];
        class_b = s.rst_ctrl[SOFT_RST_BIT]
            | (press & s.rst_ctrl[SW_EN_BIT]);
        class_c = press & ~s.rst_ctrl[SW_EN_BIT];
        class_d = s.pwr_prev & ~s.pwr_ctrl[PWR_BIT];
        // seconds tick and calendar
        tick = s.tick_cnt == 32'(TICK_COUNT - 1);
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
        if (tick) begin
            if (s.cal[SEC_POS] == SEC_WRAP) begin
                next_s.cal[SEC_POS] = 8'h00;
                next_s.cal[MIN_POS] = s.cal[MIN_POS] + 8'h01;
            end else begin
                next_s.cal[SEC_POS] = s.cal[SEC_POS] + 8'h01;
            end
        end
        // write address and data, taken in either order
        if (s.awready && awvalid) begin
            next_s.widx = awaddr[IDX_W+1:2];
            next_s.aw_held = 1'b1;
        end
        if (s.wready && wvalid) begin
            next_s.wbyte = wdata[7:0];
            next_s.wlane = wstrb[0];
            next_s.w_held = 1'b1;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        wr_fire = s.aw_held & s.w_held & ~s.bvalid;
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_hit(s.widx) ? RESP_OKAY : RESP_SLVERR;
            if (s.wlane) begin
                if (in_window(s.widx)) begin
                    if (s.eep_ctrl[EEP_EN_BIT]) begin
                        next_s.eep[s.widx[EEP_AW-1:0]] = s.wbyte;
                    end
                end else if (s.widx >= IDX_CAL_FIRST
                        && s.widx < IDX_CAL_FIRST + 10'(CAL_REGS)) begin
                    next_s.cal[3'(s.widx - IDX_CAL_FIRST)] = s.wbyte;
                end else if (s.widx >= IDX_ALM_FIRST
                        && s.widx < IDX_ALM_FIRST + 10'(ALM_REGS)) begin
                    next_s.alm[3'(s.widx - IDX_ALM_FIRST)] = s.wbyte;
                end else begin
                    case (s.widx)
                        IDX_LED: next_s.led = s.wbyte;
                        IDX_EEP_CTRL: begin
                            next_s.eep_ctrl = s.wbyte & EEP_CTRL_MASK;
                        end
                        IDX_VOL_R: next_s.vol_r = s.wbyte;
                        IDX_VOL_L: next_s.vol_l = s.wbyte;
                        IDX_CLK_CTRL: next_s.clk_ctrl = s.wbyte;
                        IDX_CLK_STAT: next_s.clk_stat = s.wbyte;
                        IDX_IRQ_STAT: begin
                            next_s.irq_stat = s.irq_stat & s.wbyte;
                        end
                        IDX_RST_CTRL: begin
                            next_s.rst_ctrl = s.wbyte & RST_CTRL_MASK;
                        end
                        IDX_PWR_CTRL: next_s.pwr_ctrl = s.wbyte;
                        default: next_s.led = s.led;
                    endcase
                end
            end
        end
        next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
        next_s.wready = ~next_s.w_held & ~next_s.bvalid;
        // read channel
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        if (s.arready && arvalid) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = reg_hit(araddr[IDX_W+1:2])
                ? RESP_OKAY : RESP_SLVERR;
            next_s.rdata = {24'h0, read_byte(s, araddr[IDX_W+1:2])};
        end
        next_s.pwr_prev = s.pwr_ctrl[PWR_BIT];
        // reset classes win over the bus; eep bytes are cleared only by reset, never by a class
        if (class_a) begin
            next_s = reinit(next_s, 1'b1);
        end else if (class_b) begin
            next_s = reinit(next_s, 1'b0);
            next_s.alm = s.alm;
            next_s.clk_stat = s.clk_stat;
        end else if (class_d) begin
            next_s = reinit(next_s, 1'b0);
            next_s.alm = s.alm;
            next_s.clk_stat = s.clk_stat;
            next_s.led = LED_POWER_DOWN;
            next_s.pwr_ctrl = PWR_POWER_DOWN;
            next_s.pwr_prev = PWR_POWER_DOWN[PWR_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign led_on_bit = s.led;
    assign eeprom_enable = s.eep_ctrl[EEP_EN_BIT];
    assign right_volume_level = s.vol_r;
    assign left_volume_level = s.vol_l;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;

    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    sequence vol_r_write;
        wr_fire && s.widx == IDX_VOL_R && s.wlane;
    endsequence
    sequence quiet_cycle;
        !class_a && !class_b && !class_d;
    endsequence

    a_eep_ctrl_init: assert property ($past(reset) |-> !eeprom_enable)
        else $error("eeprom enable not clear after reset");
    a_vol_init: assert property ($past(reset) |->
        right_volume_level == VOL_RST && left_volume_level == VOL_RST)
        else $error("volume not reset");
    a_vol_write: assert property (vol_r_write and quiet_cycle |=>
        right_volume_level == $past(s.wbyte))
        else $error("right volume write lost");
    a_eep_gate: assert property (wr_fire && in_window(s.widx)
        && !s.eep_ctrl[EEP_EN_BIT] |=> $stable(s.eep))
        else $error("eeprom written while disabled");
    a_ctrl_upper: assert property (s.eep_ctrl[7:1] == 7'h00)
        else $error("eeprom control upper bits set");
    a_switch_hold: assert property ((class_c && !wr_fire) and quiet_cycle
        |=> $stable(s.led) && $stable(s.vol_l) && $stable(s.irq_stat))
        else $error("register changed on held switch");
    a_soft_reinit: assert property (class_b && !class_a |=>
        right_volume_level == VOL_RST && s.clk_ctrl == CLK_CTRL_RST
        && $stable(s.alm) && $stable(s.clk_stat))
        else $error("soft reset class wrong");
    a_cal_keep: assert property (class_b && !class_a && !tick
        && !wr_fire |=> $stable(s.cal))
        else $error("calendar disturbed by soft reset");
    a_hard_init: assert property (class_a |=> s.cal == '0
        && s.alm == '0 && s.clk_stat == CLK_STAT_RST)
        else $error("hard reset incomplete");
    a_power_down: assert property (class_d && !class_a && !class_b
        |=> led_on_bit == LED_POWER_DOWN && s.irq_stat == IRQ_RST)
        else $error("power down class wrong");
    a_write_answer: assert property (s.aw_held && s.w_held
        |-> ##[0:1] bvalid)
        else $error("write answer missing");

endmodule

//--- hw/bcrb_pkg.sv
/*
 constants of the board controller register bank: register indices,
 field positions, reset values, bus answers and timing.
 assumes a 32-bit axi4-lite bus; byte address is four times the index.
*/
package bcrb_pkg;
    // register indices (byte address = 4 * index)
    localparam int IDX_W = 10;
    localparam logic [9:0] IDX_LED = 10'h0a0;
    localparam logic [9:0] IDX_EEP_CTRL = 10'h0c0;
    localparam logic [9:0] IDX_VOL_R = 10'h0d0;
    localparam logic [9:0] IDX_VOL_L = 10'h0d1;
    localparam logic [9:0] IDX_EEP_FIRST = 10'h100;
    localparam logic [9:0] IDX_EEP_LAST = 10'h17f;
    localparam logic [9:0] IDX_CLK_CTRL = 10'h080;
    localparam logic [9:0] IDX_CLK_STAT = 10'h081;
    localparam logic [9:0] IDX_CAL_FIRST = 10'h088;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h090;
    localparam logic [9:0] IDX_ALM_FIRST = 10'h098;
    localparam logic [9:0] IDX_RST_CTRL = 10'h0e0;
    localparam logic [9:0] IDX_PWR_CTRL = 10'h0e1;
    // sizes
    localparam int EEP_BYTES = 128;
    localparam int EEP_AW = 7;
    localparam int CAL_REGS = 7;
    localparam int ALM_REGS = 6;
    // field positions
    localparam int EEP_EN_BIT = 0;
    localparam int SOFT_RST_BIT = 0;
    localparam int SW_EN_BIT = 1;
    localparam int PWR_BIT = 0;
    localparam int SEC_POS = 0;
    localparam int MIN_POS = 1;
    // reset values, power-down values, field masks and the seconds wrap
    localparam logic [7:0] LED_RST = 8'h00;
    localparam logic [7:0] LED_POWER_DOWN = 8'h00;
    localparam logic [7:0] EEP_CTRL_RST = 8'h00;
    localparam logic [7:0] EEP_CTRL_MASK = 8'h01;
    localparam logic [7:0] VOL_RST = 8'h00;
    localparam logic [7:0] RST_CTRL_RST = 8'h00;
    localparam logic [7:0] RST_CTRL_MASK = 8'h03;
    localparam logic [7:0] PWR_RST = 8'h01;
    localparam logic [7:0] PWR_POWER_DOWN = 8'h00;
    localparam logic [7:0] CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] CLK_STAT_RST = 8'h00;
    localparam logic [7:0] CAL_RST = 8'h00;
    localparam logic [7:0] ALM_RST = 8'h00;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK = 8'h1f;
    localparam logic [7:0] SEC_WRAP = 8'h3b;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam longint CLK_PERIOD_NS = 5;
    localparam longint SECOND_NS = 1000000000;
    localparam int TICK_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

//--- verification/bcrb_host.sv
/*
 host processor model: axi4-lite master with one write and one read task.
 assumes mclk from the bench and a bench task hang for stuck answers.
*/
`timescale 1ns/1ps
module bcrb_host
    import bcrb_pkg::*;
(
    // clock
    input wire logic mclk,
    // write channels
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read channels
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // lag holds bready low for that many edges: a slow host
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int lag,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        do begin
            @(posedge mclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (n == lag) bready <= 1'b1;
            if (n > 64) testbench.hang();
        end while (!(bvalid && bready));
        bready <= 1'b0;
        r = bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (n > 64) testbench.hang();
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
endmodule

//--- verification/bcrb_tb.sv
/*
 self-checking bench of the board controller register bank.
 assumes the host model drives the bus; seconds tick cut to 8 cycles.
*/
`timescale 1ns/1ps
module testbench
    import bcrb_pkg::*;
;
    logic mclk, reset, hard_reset_input, switch_reset_input;
    logic [7:0] led_on_bit, right_volume_level, left_volume_level;
    logic eeprom_enable, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int bad_count;
    int checks;

    bcrb_top #(.ADDR_W(12), .TICK_COUNT(8)) u_dut (
        .mclk, .reset, .hard_reset_input, .switch_reset_input,
        .led_on_bit, .eeprom_enable, .right_volume_level,
        .left_volume_level, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    bcrb_host u_host (
        .mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    always #2.5 mclk = ~mclk;

    task automatic end_of_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        $display("mismatch at %0t: bus answer timed out", $time);
        end_of_test();
    endtask
    task automatic cmp(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    function automatic logic [11:0] ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic put(input logic [9:0] idx, input logic [7:0] v,
                       input logic [1:0] er);
        logic [1:0] r;
        u_host.wr(ba(idx), {24'h000000, v}, 4'h1, 0, r);
        cmp({30'h0, r}, {30'h0, er}, "write response");
    endtask
    task automatic get(input logic [9:0] idx, input logic [7:0] v,
                       input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(ba(idx), d, r);
        cmp({30'h0, r}, {30'h0, er}, "read response");
        cmp(d, {24'h000000, v}, "read data");
    endtask
    // pulse the hard reset pin or the reset switch
    task automatic press(input bit hard);
        @(posedge mclk);
        if (hard) hard_reset_input <= 1'b1;
        else switch_reset_input <= 1'b1;
        repeat (4) @(posedge mclk);
        hard_reset_input <= 1'b0;
        switch_reset_input <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic prime();
        put(IDX_LED, 8'h33, RESP_OKAY);
        put(IDX_VOL_R, 8'h44, RESP_OKAY);
        put(IDX_VOL_L, 8'h55, RESP_OKAY);
        put(IDX_EEP_CTRL, 8'h01, RESP_OKAY);
        put(IDX_ALM_FIRST, 8'h17, RESP_OKAY);
        put(IDX_CAL_FIRST, 8'h10, RESP_OKAY);
    endtask
    // compare the primed registers after a reset class
    task automatic after(input logic [7:0] led, vr, vl, alm, en,
                         input bit kept);
        logic [31:0] d;
        logic [1:0] r;
        get(IDX_LED, led, RESP_OKAY);
        get(IDX_VOL_R, vr, RESP_OKAY);
        get(IDX_VOL_L, vl, RESP_OKAY);
        get(IDX_EEP_CTRL, en, RESP_OKAY);
        get(IDX_ALM_FIRST, alm, RESP_OKAY);
        u_host.rd(ba(IDX_CAL_FIRST), d, r);
        cmp({31'h0, d[7:0] > 8'h10}, {31'h0, kept}, "seconds counter");
    endtask

    task automatic t_reset_values();
        get(IDX_EEP_CTRL, 8'h00, RESP_OKAY);
        get(IDX_VOL_R, 8'h00, RESP_OKAY);
        get(IDX_VOL_L, 8'h00, RESP_OKAY);
        cmp({31'h0, eeprom_enable}, 32'h0, "enable pin");
    endtask
    task automatic t_volume();
        logic [7:0] v [3] = '{8'h00, 8'hff, 8'h5a};
        foreach (v[i]) begin
            put(IDX_VOL_R, v[i], RESP_OKAY);
            put(IDX_VOL_L, ~v[i], RESP_OKAY);
            get(IDX_VOL_R, v[i], RESP_OKAY);
            get(IDX_VOL_L, ~v[i], RESP_OKAY);
            cmp({16'h0, right_volume_level, left_volume_level},
                {16'h0, v[i], ~v[i]}, "volume pins");
        end
    endtask
    task automatic t_led();
        logic [1:0] r;
        put(IDX_LED, 8'h01, RESP_OKAY);
        cmp({24'h0, led_on_bit}, 32'h1, "first led");
        put(IDX_LED, 8'h80, RESP_OKAY);
        cmp({24'h0, led_on_bit}, 32'h80, "eighth led");
        put(IDX_LED, 8'h5a, RESP_OKAY);
        u_host.wr(ba(IDX_LED), 32'h000000ff, 4'h0, 3, r);
        cmp({30'h0, r}, {30'h0, RESP_OKAY}, "strobe response");
        get(IDX_LED, 8'h5a, RESP_OKAY);
    endtask
    task automatic t_eeprom();
        put(IDX_EEP_CTRL, 8'hff, RESP_OKAY);
        get(IDX_EEP_CTRL, 8'h01, RESP_OKAY);
        cmp({31'h0, eeprom_enable}, 32'h1, "enable pin");
        for (int i = 0; i < EEP_BYTES; i++) begin
            put(IDX_EEP_FIRST + 10'(i), 8'(i) ^ 8'h3c, RESP_OKAY);
        end
        for (int i = 0; i < EEP_BYTES; i++) begin
            get(IDX_EEP_FIRST + 10'(i), 8'(i) ^ 8'h3c, RESP_OKAY);
        end
        // first index past the window
        put(10'h180, 8'h11, RESP_SLVERR);
        get(10'h180, 8'h00, RESP_SLVERR);
        put(IDX_EEP_CTRL, 8'h00, RESP_OKAY);
        cmp({31'h0, eeprom_enable}, 32'h0, "enable pin");
        get(IDX_EEP_FIRST, 8'h00, RESP_OKAY);
        put(IDX_EEP_FIRST, 8'hee, RESP_OKAY);
        put(IDX_EEP_CTRL, 8'h01, RESP_OKAY);
        get(IDX_EEP_FIRST, 8'h3c, RESP_OKAY);
    endtask
    task automatic t_classes();
        prime();
        put(IDX_RST_CTRL, 8'h01, RESP_OKAY);
        after(8'h00, 8'h00, 8'h00, 8'h17, 8'h00, 1);
        get(IDX_RST_CTRL, 8'h00, RESP_OKAY);
        get(IDX_CLK_CTRL, 8'h00, RESP_OKAY);
        prime();
        press(0);
        after(8'h33, 8'h44, 8'h55, 8'h17, 8'h01, 1);
        put(IDX_RST_CTRL, 8'h02, RESP_OKAY);
        prime();
        press(0);
        after(8'h00, 8'h00, 8'h00, 8'h17, 8'h00, 1);
        prime();
        put(IDX_PWR_CTRL, 8'h00, RESP_OKAY);
        after(8'h00, 8'h00, 8'h00, 8'h17, 8'h00, 1);
        get(IDX_PWR_CTRL, 8'h00, RESP_OKAY);
        put(IDX_PWR_CTRL, 8'h01, RESP_OKAY);
        prime();
        press(1);
        after(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0);
        get(IDX_PWR_CTRL, PWR_RST, RESP_OKAY);
    endtask

    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        hard_reset_input = 1'b0;
        switch_reset_input = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_reset_values();
        t_volume();
        t_led();
        t_eeprom();
        t_classes();
        end_of_test();
    end
endmodule
